// File: logic/prqc_pkg.sv
// shared constants and decode for the ratio and quiesce control block
package prqc_pkg;
  localparam int RATIO_W = 6;
  localparam int MULT_W = 8;
  localparam logic [5:0] CODE_BYPASS = 6'h0C;
  localparam logic [5:0] CODE_OFF = 6'h3C;
  localparam logic [5:0] CODE_RESET_DEF = 6'h1A;
  localparam logic [7:0] CORE_STEP = 8'h04;
  localparam logic [7:0] LOW_MULT_LIMIT = 8'h14;
  localparam logic [1:0] SYNC_STAGES = 2'h2;
  localparam logic [3:0] ADDRESS_ACK_IN_FAST_CYC = 4'h1;
  localparam logic [3:0] ADDRESS_ACK_IN_SLOW_CYC = 4'h3;
  localparam logic [31:0] CTRL_OFS = 32'h0000_0000;
  localparam logic [31:0] STAT_OFS = 32'h0000_0004;
  localparam int CTRL_HOLD_BIT = 8;
  localparam int CTRL_SYSACK_BIT = 9;
  localparam int CTRL_FACTORY_BIT = 10;
  localparam int STAT_REJECT_BIT = 6;
  localparam int STAT_QREQ_BIT = 7;
  localparam int STAT_LOWM_BIT = 8;
  localparam int STAT_HRST_BIT = 9;
  localparam logic [31:0] CTRL_RESET = 32'h0000_011A;
  typedef enum logic [1:0] {
    MODE_PLL = 2'b00, MODE_BYPASS = 2'b01, MODE_OFF = 2'b10
  } prqc_mode_e;
  typedef enum logic [1:0] {
    DFS_NONE = 2'b00, DFS_DIV2 = 2'b01, DFS_DIV4 = 2'b10
  } prqc_dfs_e;
  // bus-to-core multiplier in quarter steps, zero when not a multiplier code
  function automatic logic [7:0] ratio_mult4(input logic [5:0] code);
    unique case (code)
      6'h26: ratio_mult4 = 8'h2C;
      6'h00: ratio_mult4 = 8'h2E;
      6'h2E: ratio_mult4 = 8'h30;
      6'h3E: ratio_mult4 = 8'h32;
      6'h16: ratio_mult4 = 8'h34;
      6'h38: ratio_mult4 = 8'h36;
      6'h32: ratio_mult4 = 8'h38;
      6'h06: ratio_mult4 = 8'h3C;
      6'h36: ratio_mult4 = 8'h40;
      6'h02: ratio_mult4 = 8'h44;
      6'h0A: ratio_mult4 = 8'h48;
      6'h0E: ratio_mult4 = 8'h50;
      6'h12: ratio_mult4 = 8'h54;
      6'h1A: ratio_mult4 = 8'h60;
      6'h3A: ratio_mult4 = 8'h70;
      default: ratio_mult4 = 8'h00;
    endcase
  endfunction : ratio_mult4
  // true for every listed code, multipliers plus bypass and off
  function automatic logic code_listed(input logic [5:0] code);
    code_listed = (ratio_mult4(code) != 8'h00) || (code == CODE_BYPASS) || (code == CODE_OFF);
  endfunction : code_listed
endpackage : prqc_pkg

// File: logic/prqc_link_if.sv
// link between the configured processor end and the board control end
`timescale 1ns/1ps
`default_nettype none
interface prqc_link_if;
  logic [5:0] ratio_sel;
  logic hard_reset_n;
  logic test_reset_n;
  logic bypass_bus_qualifier;
  logic quiesce_ack_n;
  logic address_ack_n;
  logic quiesce_req;
  logic addr_start;
  logic low_mult;
  modport dev (
    input ratio_sel, hard_reset_n, test_reset_n, bypass_bus_qualifier, quiesce_ack_n, address_ack_n,
    output quiesce_req, addr_start, low_mult
  );
  modport host (
    output ratio_sel, hard_reset_n, test_reset_n, bypass_bus_qualifier, quiesce_ack_n, address_ack_n,
    input quiesce_req, addr_start, low_mult
  );
endinterface : prqc_link_if
`default_nettype wire

// File: logic/prqc_host.sv
// board control end: register slave, reset merge, qualifier, quiesce merge, address ack
`timescale 1ns/1ps
`default_nettype none
module prqc_host (
  input wire logic CLK_I,
  input wire logic RESET_N_I,
  prqc_link_if.host LINK,
  input wire logic HSEL_I,
  input wire logic [31:0] HADDR_I,
  input wire logic [1:0] HTRANS_I,
  input wire logic HWRITE_I,
  input wire logic [2:0] HSIZE_I,
  input wire logic [31:0] HWDATA_I,
  input wire logic HREADY_I,
  output logic HREADYOUT_O,
  output logic HRESP_O,
  output logic [31:0] HRDATA_O,
  input wire logic DEBUG_ATTACHED_I,
  input wire logic DEBUG_HARD_RESET_IN_REQ_I,
  input wire logic DEBUG_TRESET_REQ_I,
  input wire logic DEBUG_QUIESCE_ACK_IN_I,
  input wire logic SYS_RESET_REQ_I
);
  import prqc_pkg::*;
  logic [4:0] s1_q, s2_q;
  logic [2:0] l1_q, l2_q;
  logic [31:0] ctrl_q, ctrl_d, rdata_q, rdata_d;
  logic reject_q, reject_d, wr_q, wr_d, qual_q, qual_d, start_q, start_d;
  logic [31:0] wad_q, wad_d;
  logic [3:0] cnt_q, cnt_d;
  logic ack_q, ack_d, hard_rst, take, wr_ctrl;
  logic [5:0] new_code;
  // two-flop synchronisers for board pins and link inputs
  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      s1_q <= 5'h00;
      s2_q <= 5'h00;
      l1_q <= 3'h0;
      l2_q <= 3'h0;
    end else begin
      s1_q <= {SYS_RESET_REQ_I, DEBUG_QUIESCE_ACK_IN_I, DEBUG_TRESET_REQ_I, DEBUG_HARD_RESET_IN_REQ_I, DEBUG_ATTACHED_I};
      s2_q <= s1_q;
      l1_q <= {LINK.low_mult, LINK.addr_start, LINK.quiesce_req};
      l2_q <= l1_q;
    end
  end
  // hold bit, debugger hard reset request and system reset request merged into the hard reset
  assign hard_rst = ctrl_q[CTRL_HOLD_BIT] | s2_q[1] | s2_q[4];
  assign take = HSEL_I && HREADY_I && HTRANS_I[1];
  assign wr_ctrl = wr_q && (wad_q == CTRL_OFS);
  assign new_code = HWDATA_I[5:0];
  // register slave next state
  always_comb begin
    ctrl_d = ctrl_q;
    reject_d = reject_q;
    wr_d = take && HWRITE_I;
    wad_d = take ? HADDR_I : wad_q;
    rdata_d = 32'h0000_0000;
    if (take && !HWRITE_I && HADDR_I == CTRL_OFS) begin
      rdata_d = ctrl_q;
    end else if (take && !HWRITE_I && HADDR_I == STAT_OFS) begin
      rdata_d = {22'h000000, hard_rst, l2_q[2], l2_q[0], reject_q, LINK.ratio_sel};
    end
    if (wr_q && wad_q == STAT_OFS && HWDATA_I[STAT_REJECT_BIT]) begin
      reject_d = 1'b0;
    end
    if (wr_ctrl) begin
      ctrl_d[31:6] = {21'h000000, HWDATA_I[CTRL_FACTORY_BIT:CTRL_HOLD_BIT], 2'h0};
      // code only changes under reset, listed, bypass only in factory use
      if (hard_rst && code_listed(new_code) && (new_code != CODE_BYPASS || HWDATA_I[CTRL_FACTORY_BIT])) begin
        ctrl_d[5:0] = new_code;
      end else if (new_code != ctrl_q[5:0]) begin
        reject_d = 1'b1;
      end
    end
  end
  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      ctrl_q <= CTRL_RESET;
      reject_q <= 1'b0;
      wr_q <= 1'b0;
      wad_q <= 32'h0000_0000;
      rdata_q <= 32'h0000_0000;
    end else begin
      ctrl_q <= ctrl_d;
      reject_q <= reject_d;
      wr_q <= wr_d;
      wad_q <= wad_d;
      rdata_q <= rdata_d;
    end
  end
  assign HREADYOUT_O = 1'b1;
  assign HRESP_O = 1'b0;
  assign HRDATA_O = rdata_q;
  // qualifier at half clock rate in bypass, address ack timing
  always_comb begin
    qual_d = (ctrl_q[5:0] == CODE_BYPASS) ? !qual_q : 1'b0;
    start_d = l2_q[1];
    cnt_d = cnt_q;
    ack_d = 1'b0;
    if (l2_q[1] && !start_q) begin
      cnt_d = l2_q[2] ? ADDRESS_ACK_IN_SLOW_CYC : ADDRESS_ACK_IN_FAST_CYC;
    end else if (cnt_q != 4'h0) begin
      cnt_d = cnt_q - 4'h1;
      ack_d = (cnt_q == 4'h1);
    end
  end
  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      qual_q <= 1'b0;
      start_q <= 1'b0;
      cnt_q <= 4'h0;
      ack_q <= 1'b0;
    end else begin
      qual_q <= qual_d;
      start_q <= start_d;
      cnt_q <= cnt_d;
      ack_q <= ack_d;
    end
  end
  // link drive, ratio held static from the register
  assign LINK.ratio_sel = ctrl_q[5:0];
  assign LINK.hard_reset_n = !hard_rst;
  // test reset follows hard reset when no debugger is attached
  assign LINK.test_reset_n = !(s2_q[0] ? s2_q[2] : hard_rst);
  // ack merged from emulator, debugger presence and system grant
  assign LINK.quiesce_ack_n = !(s2_q[3] | s2_q[0] | (ctrl_q[CTRL_SYSACK_BIT] & l2_q[0]));
  assign LINK.bypass_bus_qualifier = qual_q;
  assign LINK.address_ack_n = !ack_q;
endmodule : prqc_host
`default_nettype wire

// File: logic/prqc_dev.sv
// processor end: ratio strap capture, core and bus clock pacing, quiesce and ack
// What this block does
// - decode six-bit code to multipliers 11x-28x
// - off code stops all internal clocking
// - far end applies only listed codes
// - far end toggles qualifier at half rate
// - bypass bus runs half, core full rate
// - bypass only for factory or emulator use
// - far end delays ack below 5x
// - scaling modes change the chosen multiplier
// - asserted quiesce ack permits quiescent state
// - debug needs quiesce ack held low
// - quiesce ack merged from debugger and system
// - board merges hold, debugger hard and system resets first
// - test reset follows hard reset unused
//
// The AHB-Lite slave port and the address map were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module prqc_dev (
  input wire logic CLK_I,
  input wire logic RESET_N_I,
  prqc_link_if.dev LINK,
  input wire prqc_pkg::prqc_dfs_e DFS_MODE_I,
  input wire logic LOW_POWER_I,
  input wire logic ADDR_START_I,
  output logic CORE_TICK_O,
  output logic BUS_TICK_O,
  output prqc_pkg::prqc_mode_e MODE_O,
  output logic [prqc_pkg::MULT_W-1:0] EFF_MULT_O,
  output logic CONFIG_VALID_O,
  output logic QUIESCENT_O,
  output logic DEBUG_READY_O,
  output logic ADDR_ACKED_O
);
  import prqc_pkg::*;

  typedef enum logic [1:0] {
    ST_HOLD = 2'b00,
    ST_RUN = 2'b01,
    ST_QUIET = 2'b10
  } prqc_state_e;

  // synchronised copies of link pins, address ack taken direct without synchronising
  logic [9:0] p1_q, p2_q;
  logic qual_q;
  logic [5:0] code_s;
  logic hrst_s, trst_s, quiesce_ack_in_s, address_ack_in_s, qual_s;

  // captured configuration
  prqc_state_e st_q, st_d;
  logic [5:0] code_q, code_d;
  prqc_mode_e mode_q, mode_d;
  logic [7:0] base_q, base_d;
  logic [7:0] eff_q, eff_d;
  logic [7:0] acc_q, acc_d;
  logic [7:0] acc_sum;
  logic core_q, core_d;
  logic bus_q, bus_d;
  logic lowm_q, lowm_d;

  // address request bookkeeping
  logic pend_q, pend_d;
  logic start_q, start_d;
  logic acked_q, acked_d;
  logic address_ack_in_old_q;

  // two flops on every incoming link pin except address_ack_n, which is used unsynchronised
  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      p1_q <= 10'h001; // idle levels, quiesce ack negated, resets asserted
      p2_q <= 10'h001; // no false ack grant right after reset
      qual_q <= 1'b0;
      address_ack_in_old_q <= 1'b0;
    end else begin
      p1_q <= {LINK.ratio_sel, LINK.hard_reset_n, LINK.test_reset_n,
               LINK.bypass_bus_qualifier, LINK.quiesce_ack_n};
      p2_q <= p1_q;
      qual_q <= qual_s;
      address_ack_in_old_q <= address_ack_in_s;
    end
  end

  // code stays static after release, so a bit-wise sync is safe
  assign code_s = p2_q[9:4];
  assign hrst_s = !p2_q[3];
  assign trst_s = !p2_q[2];
  assign qual_s = p2_q[1];
  assign quiesce_ack_in_s = !p2_q[0];
  assign address_ack_in_s = !LINK.address_ack_n;

  // capture, mode decode and pacing
  always_comb begin
    st_d = st_q;
    code_d = code_q;
    mode_d = mode_q;
    base_d = base_q;
    eff_d = eff_q;
    acc_d = acc_q;
    core_d = 1'b0;
    bus_d = 1'b0;
    acc_sum = acc_q + CORE_STEP;
    unique case (st_q)
      ST_HOLD: begin
        // strap caught every cycle while hard reset is asserted
        code_d = code_s;
        acc_d = 8'h00;
        if (code_s == CODE_OFF) begin
          mode_d = MODE_OFF;
        end else if (code_s == CODE_BYPASS) begin
          mode_d = MODE_BYPASS;
        end else begin
          mode_d = MODE_PLL;
        end
        base_d = ratio_mult4(code_s);
        if (!hrst_s) begin
          st_d = ST_RUN;
        end
      end
      ST_RUN, ST_QUIET: begin
        // scaling divides the configured multiplier
        unique case (DFS_MODE_I)
          DFS_DIV2: eff_d = {1'b0, base_q[7:1]};
          DFS_DIV4: eff_d = {2'b00, base_q[7:2]};
          default: eff_d = base_q;
        endcase
        if (st_q == ST_RUN) begin
          unique case (mode_q)
            MODE_BYPASS: begin
              core_d = 1'b1;
              bus_d = qual_s && !qual_q;
            end
            MODE_PLL: begin
              core_d = (eff_q != 8'h00);
              if (eff_q != 8'h00 && acc_sum >= eff_q) begin
                acc_d = acc_sum - eff_q;
                bus_d = 1'b1;
              end else if (eff_q != 8'h00) begin
                acc_d = acc_sum;
              end
            end
            default: begin
              core_d = 1'b0;
            end
          endcase
          // quiescent only on request with ack granted
          if (LOW_POWER_I && quiesce_ack_in_s) begin
            st_d = ST_QUIET;
          end
        end else if (!LOW_POWER_I) begin
          st_d = ST_RUN;
        end
        if (hrst_s) begin
          st_d = ST_HOLD;
        end
      end
      default: begin
        st_d = ST_HOLD;
      end
    endcase
    // low multiplier warning for ack spacing
    lowm_d = (mode_q == MODE_PLL) && (eff_d < LOW_MULT_LIMIT);
  end

  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      st_q <= ST_HOLD;
      code_q <= CODE_RESET_DEF;
      mode_q <= MODE_OFF;
      base_q <= 8'h00;
      eff_q <= 8'h00;
      acc_q <= 8'h00;
      core_q <= 1'b0;
      bus_q <= 1'b0;
      lowm_q <= 1'b0;
    end else begin
      st_q <= st_d;
      code_q <= code_d;
      mode_q <= mode_d;
      base_q <= base_d;
      eff_q <= eff_d;
      acc_q <= acc_d;
      core_q <= core_d;
      bus_q <= bus_d;
      lowm_q <= lowm_d;
    end
  end

  // address request held until the delayed ack arrives
  always_comb begin
    pend_d = pend_q;
    start_d = start_q;
    acked_d = 1'b0;
    if (ADDR_START_I && !pend_q && st_q == ST_RUN) begin
      pend_d = 1'b1;
      start_d = 1'b1;
    end else if (pend_q && address_ack_in_s && !address_ack_in_old_q) begin
      pend_d = 1'b0;
      start_d = 1'b0;
      acked_d = 1'b1;
    end
    if (st_q == ST_HOLD) begin
      pend_d = 1'b0;
      start_d = 1'b0;
    end
  end

  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      pend_q <= 1'b0;
      start_q <= 1'b0;
      acked_q <= 1'b0;
    end else begin
      pend_q <= pend_d;
      start_q <= start_d;
      acked_q <= acked_d;
    end
  end

  // outputs
  assign CORE_TICK_O = core_q;
  assign BUS_TICK_O = bus_q;
  assign MODE_O = mode_q;
  assign EFF_MULT_O = eff_q;
  assign CONFIG_VALID_O = (st_q != ST_HOLD) && code_listed(code_q);
  assign QUIESCENT_O = (st_q == ST_QUIET);
  // debug port usable only with ack held and test reset released
  assign DEBUG_READY_O = quiesce_ack_in_s && !trst_s;
  assign ADDR_ACKED_O = acked_q;
  assign LINK.quiesce_req = LOW_POWER_I && (st_q != ST_HOLD);
  assign LINK.addr_start = start_q;
  assign LINK.low_mult = lowm_q;
endmodule : prqc_dev
`default_nettype wire

// File: test/prqc_chk.sv
// link checker for the ratio and quiesce control ends
`timescale 1ns/1ps
`default_nettype none
module prqc_chk (
  input wire logic CLK_I,
  input wire logic RESET_N_I,
  input wire logic [5:0] ratio_sel,
  input wire logic hard_reset_n,
  input wire logic test_reset_n,
  input wire logic bypass_bus_qualifier,
  input wire logic quiesce_ack_n,
  input wire logic address_ack_n,
  input wire logic quiesce_req,
  input wire logic addr_start,
  input wire logic low_mult
);
  import prqc_pkg::*;
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RESET_N_I);
  // qualifier runs at half rate in bypass only
  a_qual_toggle: assert property ((ratio_sel == CODE_BYPASS) [*2] |-> bypass_bus_qualifier != $past(bypass_bus_qualifier))
    else $error("qualifier stalled in bypass");
  a_qual_idle: assert property ((ratio_sel != CODE_BYPASS) [*3] |-> !bypass_bus_qualifier)
    else $error("qualifier active outside bypass");
  // code only moves while hard reset is asserted
  a_code_stable: assert property (hard_reset_n && $past(hard_reset_n) |-> $stable(ratio_sel))
    else $error("code moved while running");
  // ack is one cycle, answers a request, late when multiplier is low
  a_ack_pulse: assert property (!address_ack_n |=> address_ack_n)
    else $error("ack longer than one cycle");
  a_ack_fast: assert property ($rose(addr_start) && !low_mult |-> ##[3:5] !address_ack_n)
    else $error("fast ack late");
  a_ack_slow: assert property ($rose(addr_start) && low_mult |-> address_ack_n [*5] ##[1:3] !address_ack_n)
    else $error("low multiplier ack not delayed");
  a_ack_pending: assert property ($fell(address_ack_n) |-> addr_start)
    else $error("ack without request");
  a_start_drop: assert property (!address_ack_n |-> ##[1:2] !addr_start)
    else $error("request kept after ack");
  // main scenarios
  c_bypass: cover property ($rose(bypass_bus_qualifier));
  c_fast: cover property ($fell(address_ack_n) && !low_mult);
  c_slow: cover property ($fell(address_ack_n) && low_mult);
  c_quiet: cover property (quiesce_req && !quiesce_ack_n);
  c_treset: cover property (!test_reset_n && hard_reset_n);
endmodule : prqc_chk
`default_nettype wire

// File: test/pll_ratio_and_quiesce_control_tb.sv
// bench joining both ends of the ratio and quiesce control block
`timescale 1ns/1ps
`default_nettype none
module pll_ratio_and_quiesce_control_tb;
  import prqc_pkg::*;
  logic CLK_I, RESET_N_I, hsel, hwrite, hrdy, hresp, lp, ast, att, dhr, dtr, dqk, srr;
  logic ctk, btk, cfgv, quies, dbgr, acked;
  logic [1:0] htrans;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [7:0] mult;
  logic [5:0] cur;
  prqc_dfs_e dynamic_freq_scaling;
  prqc_mode_e mode;
  int mismatches, checks, nc, nb, d;
  logic [5:0] cd [15] = '{6'h26, 6'h00, 6'h2E, 6'h3E, 6'h16, 6'h38, 6'h32, 6'h06, 6'h36, 6'h02, 6'h0A, 6'h0E,
    6'h12, 6'h1A, 6'h3A};
  logic [7:0] ml [15] = '{8'h2C, 8'h2E, 8'h30, 8'h32, 8'h34, 8'h36, 8'h38, 8'h3C, 8'h40, 8'h44, 8'h48, 8'h50,
    8'h54, 8'h60, 8'h70};
  // the two ends and the link checker
  prqc_link_if prqc_link_if_inst ();
  prqc_dev prqc_dev_inst (.CLK_I(CLK_I), .RESET_N_I(RESET_N_I), .LINK(prqc_link_if_inst), .DFS_MODE_I(dynamic_freq_scaling),
    .LOW_POWER_I(lp), .ADDR_START_I(ast), .CORE_TICK_O(ctk), .BUS_TICK_O(btk), .MODE_O(mode), .EFF_MULT_O(mult),
    .CONFIG_VALID_O(cfgv), .QUIESCENT_O(quies), .DEBUG_READY_O(dbgr), .ADDR_ACKED_O(acked));
  prqc_host prqc_host_inst (.CLK_I(CLK_I), .RESET_N_I(RESET_N_I), .LINK(prqc_link_if_inst), .HSEL_I(hsel),
    .HADDR_I(haddr), .HTRANS_I(htrans), .HWRITE_I(hwrite), .HSIZE_I(3'h2), .HWDATA_I(hwdata), .HREADY_I(hrdy),
    .HREADYOUT_O(hrdy), .HRESP_O(hresp), .HRDATA_O(hrdata), .DEBUG_ATTACHED_I(att), .DEBUG_HARD_RESET_IN_REQ_I(dhr),
    .DEBUG_TRESET_REQ_I(dtr), .DEBUG_QUIESCE_ACK_IN_I(dqk), .SYS_RESET_REQ_I(srr));
  prqc_chk prqc_chk_inst (.CLK_I(CLK_I), .RESET_N_I(RESET_N_I), .ratio_sel(prqc_link_if_inst.ratio_sel),
    .hard_reset_n(prqc_link_if_inst.hard_reset_n), .test_reset_n(prqc_link_if_inst.test_reset_n),
    .bypass_bus_qualifier(prqc_link_if_inst.bypass_bus_qualifier), .quiesce_ack_n(prqc_link_if_inst.quiesce_ack_n),
    .address_ack_n(prqc_link_if_inst.address_ack_n), .quiesce_req(prqc_link_if_inst.quiesce_req),
    .addr_start(prqc_link_if_inst.addr_start), .low_mult(prqc_link_if_inst.low_mult));
  // 200 MHz clock
  initial begin
    CLK_I = 1'b0;
    forever #2.5 CLK_I = ~CLK_I;
  end
  // verdict and end of run
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : complete_run
  task automatic cmp(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("FAIL %s expected %h seen %h", nm, exp, seen);
    end
  endtask : cmp
  task automatic wt(input int n);
    repeat (n) @(posedge CLK_I);
  endtask : wt
  // one single word transfer, read data left in rd
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] v);
    int n;
    n = 0;
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    do begin @(posedge CLK_I); n++; end while (hrdy !== 1'b1 && n < 50);
    htrans <= 2'h0;
    hwdata <= v;
    do begin @(posedge CLK_I); n++; end while (hrdy !== 1'b1 && n < 50);
    rd = hrdata;
    if (n >= 50) begin mismatches++; complete_run(); end
  endtask : bus
  // new code under hard reset, then release
  task automatic cfg(input logic [5:0] c, input logic [31:0] x);
    bus(1'b1, CTRL_OFS, 32'h100 | 32'(cur));
    bus(1'b1, CTRL_OFS, 32'h100 | x | 32'(c));
    bus(1'b1, CTRL_OFS, x | 32'(c));
    cur = c;
    wt(10);
  endtask : cfg
  task automatic ticks();
    nc = 0;
    nb = 0;
    repeat (20) begin @(posedge CLK_I); nc += int'(ctk); nb += int'(btk); end
  endtask : ticks
  task automatic addr_req();
    ast <= 1'b1;
    @(posedge CLK_I);
    ast <= 1'b0;
    d = 0;
    while (acked !== 1'b1 && d < 40) begin @(posedge CLK_I); d++; end
    cmp("addr ack", 32'(acked), 32'h1);
    if (acked !== 1'b1) complete_run();
  endtask : addr_req
  // main sequence
  initial begin
    {RESET_N_I, hsel, hwrite, lp, ast, att, dhr, dtr, dqk, srr} = '0;
    htrans = 2'h0;
    haddr = '0;
    hwdata = '0;
    dynamic_freq_scaling = DFS_NONE;
    cur = 6'h1A;
    void'($urandom(65));
    wt(12);
    RESET_N_I <= 1'b1;
    wt(1);
    bus(1'b0, CTRL_OFS, 0);
    cmp("ctrl reset", rd, CTRL_RESET);
    cmp("okay", 32'(hresp), 32'h0);
    bus(1'b1, CTRL_OFS, 32'h10C);
    bus(1'b0, CTRL_OFS, 0);
    cmp("bypass refused", 32'(rd[5:0]), 32'h1A);
    bus(1'b1, CTRL_OFS, 32'h101);
    bus(1'b0, CTRL_OFS, 0);
    cmp("reserved refused", 32'(rd[5:0]), 32'h1A);
    bus(1'b0, STAT_OFS, 0);
    cmp("reject flag", 32'(rd[STAT_REJECT_BIT]), 32'h1);
    bus(1'b1, STAT_OFS, 32'h40);
    bus(1'b0, STAT_OFS, 0);
    cmp("reject clear", 32'(rd[STAT_REJECT_BIT]), 32'h0);
    bus(1'b1, CTRL_OFS, 32'h1A);
    wt(10);
    cmp("mode", 32'(mode), 32'(MODE_PLL));
    bus(1'b1, CTRL_OFS, 32'h26);
    bus(1'b0, CTRL_OFS, 0);
    cmp("code kept", 32'(rd[5:0]), 32'h1A);
    for (int i = 0; i < 15; i++) begin
      dynamic_freq_scaling <= prqc_dfs_e'($urandom_range(2));
      cfg(cd[i], 32'h0);
      cmp("mult", 32'(mult), 32'(ml[i] >> dynamic_freq_scaling));
      cmp("valid", 32'(cfgv), 32'h1);
      bus(1'b0, STAT_OFS, 0);
      cmp("low mult", 32'(rd[STAT_LOWM_BIT]), 32'((ml[i] >> dynamic_freq_scaling) < 8'h14));
    end
    dynamic_freq_scaling <= DFS_NONE;
    cfg(6'h1A, 32'h0);
    addr_req();
    addr_req();
    dynamic_freq_scaling <= DFS_DIV4;
    cfg(6'h26, 32'h0);
    addr_req();
    dynamic_freq_scaling <= DFS_NONE;
    cfg(CODE_BYPASS, 32'h400);
    cmp("bypass mode", 32'(mode), 32'(MODE_BYPASS));
    ticks();
    cmp("bypass core", nc, 20);
    cmp("bypass bus", nb, 10);
    cfg(CODE_OFF, 32'h0);
    cmp("off mode", 32'(mode), 32'(MODE_OFF));
    ticks();
    cmp("off ticks", nc + nb, 0);
    cfg(6'h1A, 32'h0);
    srr <= 1'b1;
    wt(6);
    cmp("sys hard_reset_in", 32'(prqc_link_if_inst.hard_reset_n), 32'h0);
    cmp("treset follows", 32'(prqc_link_if_inst.test_reset_n), 32'h0);
    srr <= 1'b0;
    dhr <= 1'b1;
    wt(6);
    cmp("dbg hard_reset_in", 32'(prqc_link_if_inst.hard_reset_n), 32'h0);
    dhr <= 1'b0;
    att <= 1'b1;
    dtr <= 1'b1;
    wt(6);
    cmp("hard_reset_in off", 32'(prqc_link_if_inst.hard_reset_n), 32'h1);
    cmp("dbg treset", 32'(prqc_link_if_inst.test_reset_n), 32'h0);
    dtr <= 1'b0;
    wt(10);
    cmp("debug ready", 32'(dbgr), 32'h1);
    att <= 1'b0;
    wt(10);
    lp <= 1'b1;
    wt(10);
    cmp("no grant", 32'(quies), 32'h0);
    bus(1'b0, STAT_OFS, 0);
    cmp("quiesce req", 32'(rd[STAT_QREQ_BIT]), 32'h1);
    bus(1'b1, CTRL_OFS, 32'h21A);
    wt(10);
    cmp("granted", 32'(quies), 32'h1);
    bus(1'b1, CTRL_OFS, 32'h1A);
    lp <= 1'b0;
    wt(10);
    cmp("awake", 32'(quies), 32'h0);
    dqk <= 1'b1;
    lp <= 1'b1;
    wt(10);
    cmp("emulator grant", 32'(quies), 32'h1);
    complete_run();
  end
endmodule : pll_ratio_and_quiesce_control_tb
`default_nettype wire
